//--- bench/host_bus_model.sv
// host bus model: arbiter, glue logic, memory data and transfer acknowledge
`timescale 1ns/100ps

module host_bus_model (
	input  wire       clock,
	input  wire       req_act,
	input  wire       bus_owned_n,
	input  wire       strobe_n,
	input  wire       transceiver_direction,
	input  wire [3:0] wait_cycles,
	input  wire [15:0] rd_word,
	output reg        bus_grant_in_n,
	output reg        bus_busy_in_n,
	output reg        transfer_acknowledge_in,
	output reg  [7:0] addr_data_high_byte_in,
	output reg  [7:0] addr_data_low_byte_in
);
	// ****************************************
	// arbiter and memory
	// ****************************************
	reg [3:0] cnt_r;
	initial begin
		bus_grant_in_n = 1'b1;
		bus_busy_in_n = 1'b1;
		transfer_acknowledge_in = 1'b1;
		{addr_data_high_byte_in, addr_data_low_byte_in} = 16'h0000;
		cnt_r = 4'h0;
	end
	always @(posedge clock) begin
		bus_grant_in_n <= ~(req_act & bus_owned_n);
		bus_busy_in_n <= bus_owned_n;
		cnt_r <= strobe_n ? 4'h0 : cnt_r + 4'h1;
		// slow memories hold the acknowledge off for wait_cycles
		transfer_acknowledge_in <= strobe_n | (cnt_r < wait_cycles);
		// a released bus toggles so stale data never looks valid
		if (transceiver_direction)
			{addr_data_high_byte_in, addr_data_low_byte_in} <=
				~{addr_data_high_byte_in, addr_data_low_byte_in};
		else
			{addr_data_high_byte_in, addr_data_low_byte_in} <= rd_word;
	end
endmodule

//--- bench/host_port_properties.sv
// checker for the host dma and interrupt port
`timescale 1ns/100ps

module host_port_properties (
	input logic        clock,
	input logic        nrst,
	input logic        address_strobe_mode,
	input logic        host_int_write,
	input logic [15:0] host_int_wdata,
	input logic        adapter_irq_set,
	input logic        bus_owned_n,
	input logic        low_address_latch_pulse,
	input logic        extended_address_latch_pulse,
	input logic        data_buffer_enable_n,
	input logic        transceiver_direction,
	input logic        host_interrupt_request,
	input logic        hold_or_bus_request_out,
	input logic        address_strobe_n,
	input logic        upper_data_strobe_n,
	input logic        lower_data_strobe_n,
	input logic        strobe_oe,
	input logic        read_not_write,
	input logic        read_not_write_oe,
	input logic        addr_data_high_byte_oe,
	input logic        addr_data_low_byte_oe
);
	// ****************************************
	// properties
	// ****************************************
	default clocking cb @(posedge clock); endclocking
	// request polarity follows the bus mode, so compare against the mode bit
	wire irq_on = host_interrupt_request ^ address_strobe_mode;
	wire hclr   = host_int_write & ~host_int_wdata[8];
	wire wr_cyc = read_not_write_oe & ~read_not_write;
	wire ds_n   = upper_data_strobe_n & lower_data_strobe_n;

	AST_RST_LEVELS: assert property (!nrst |=> data_buffer_enable_n && bus_owned_n &&
		transceiver_direction && !low_address_latch_pulse && !extended_address_latch_pulse)
		else $error("reset levels wrong");
	AST_RST_REQ: assert property (!nrst |=> host_interrupt_request == address_strobe_mode
		&& hold_or_bus_request_out == address_strobe_mode) else $error("reset request wrong");
	AST_RST_FLOAT: assert property (!nrst |=> !(strobe_oe | read_not_write_oe |
		addr_data_high_byte_oe | addr_data_low_byte_oe)) else $error("pin driven in reset");
	AST_LATCH_FIRST: assert property (disable iff (!nrst)
		$fell(address_strobe_n) |-> $past(low_address_latch_pulse)) else $error("no latch pulse");
	AST_READ_DIR: assert property (disable iff (!nrst)
		!address_strobe_n && strobe_oe && !wr_cyc |-> !transceiver_direction)
		else $error("read direction high");
	AST_WRITE_DIR: assert property (disable iff (!nrst)
		!address_strobe_n && wr_cyc |-> transceiver_direction && !data_buffer_enable_n)
		else $error("write direction wrong");
	AST_WRITE_DS: assert property (disable iff (!nrst)
		$fell(address_strobe_n) && wr_cyc |-> ds_n ##1 !ds_n) else $error("write strobe late");
	AST_IRQ_HOLD: assert property (disable iff (!nrst)
		irq_on && !hclr |=> irq_on) else $error("irq dropped");
	AST_READ_DS: assert property (disable iff (!nrst)
		$fell(address_strobe_n) && !wr_cyc |-> !ds_n) else $error("read strobe late");
	AST_IRQ_CLEAR: assert property (disable iff (!nrst)
		hclr && !adapter_irq_set |=> !irq_on) else $error("irq not cleared");
	cover property ($fell(address_strobe_n) && !wr_cyc);
	cover property ($fell(bus_owned_n));
	cover property ($fell(address_strobe_n) && wr_cyc);
	cover property (irq_on ##1 !irq_on);
endmodule

//--- bench/testbench.sv
// self-checking bench for the host dma and interrupt port
`timescale 1ns/100ps

module testbench;
	reg         clock, nrst, address_strobe_mode, dma_req, dma_write, adapter_irq_set;
	reg         host_int_write, adapter_int_clear, interrupt_acknowledge_n;
	reg  [1:0]  dma_byte_en;
	reg  [3:0]  wait_cycles;
	reg  [7:0]  dma_addr_ext, int_vector;
	reg  [15:0] dma_addr, dma_wdata, host_int_wdata, rd_word, m;
	reg  [17:0] cap, acap;
	reg  [8:0]  xcap;
	reg  [63:0] r;
	wire [15:0] dma_rdata;
	wire [7:0]  adapter_int_bits, addr_data_high_byte_in, addr_data_low_byte_in;
	wire [7:0]  addr_data_high_byte_out, addr_data_low_byte_out;
	wire        dma_done, bus_grant_in_n, bus_busy_in_n, hold_or_bus_request_out, bus_owned_n;
	wire        low_address_latch_pulse, extended_address_latch_pulse, data_buffer_enable_n;
	wire        transceiver_direction, host_interrupt_request, address_strobe_n, strobe_oe;
	wire        upper_data_strobe_n, lower_data_strobe_n, read_not_write, read_not_write_oe;
	wire        transfer_acknowledge_in, transfer_acknowledge_out, transfer_acknowledge_oe;
	wire        addr_data_high_byte_oe, addr_data_low_byte_oe, parity_high, parity_high_oe;
	wire        parity_low, parity_low_oe;
	wire        req_act = hold_or_bus_request_out ^ address_strobe_mode;
	wire        strobe_n = upper_data_strobe_n & lower_data_strobe_n;
	integer     seed, n_fail, check_count, cycles, k, j;

	system_interface_unit DUT (.*);
	host_bus_model host (.*);

	// ****************************************
	// tasks
	// ****************************************
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	always @(posedge clock) begin
		if (read_not_write_oe && !read_not_write && !strobe_n)
			cap <= {addr_data_high_byte_oe, addr_data_low_byte_oe,
				addr_data_high_byte_out, addr_data_low_byte_out};
		// address and its parity as the external latches would see them
		if (low_address_latch_pulse)
			acap <= {addr_data_high_byte_out, addr_data_low_byte_out, parity_high, parity_low};
		if (extended_address_latch_pulse)
			xcap <= {addr_data_low_byte_out, parity_low};
		cycles = cycles + 1;
		if (cycles == 20000) begin
			n_fail = n_fail + 1;
			end_sim;
		end
	end
	// odd parity: the parity bit makes the count of ones odd
	function par(input [7:0] b);
		begin
			par = ~(^b);
		end
	endfunction
	task check(input [15:0] seen, input [15:0] exp);
		begin
			check_count = check_count + 1;
			if (seen !== exp) begin
				n_fail = n_fail + 1;
				$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task end_sim;
		begin
			$display("checks %0d mismatches %0d", check_count, n_fail);
			if (n_fail == 0 && check_count > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task do_reset(input m_in);
		begin
			@(negedge clock) nrst = 1'b0;
			address_strobe_mode = m_in;
			repeat (4) @(negedge clock);
			check({14'h0, host_interrupt_request, hold_or_bus_request_out}, {14'h0, m_in, m_in});
			nrst = 1'b1;
			repeat (2) @(negedge clock);
		end
	endtask
	task pulse(input [1:0] sel, input [15:0] d);
		begin
			@(negedge clock) {host_int_write, adapter_irq_set} = sel;
			host_int_wdata = d;
			@(negedge clock) {host_int_write, adapter_irq_set} = 2'h0;
			@(negedge clock);
		end
	endtask
	task ack(input drive);
		begin
			k = $random(seed);
			int_vector = k[7:0];
			@(negedge clock) interrupt_acknowledge_n = 1'b0;
			repeat (3) @(negedge clock);
			check({15'h0, addr_data_low_byte_oe}, {15'h0, drive});
			check({14'h0, transceiver_direction, data_buffer_enable_n}, {14'h0, drive, ~drive});
			if (drive) begin
				check({8'h00, addr_data_low_byte_out}, {8'h00, int_vector});
				check({15'h0, parity_low}, {15'h0, par(int_vector)});
			end
			if (address_strobe_mode)
				check({14'h0, transfer_acknowledge_oe, transfer_acknowledge_out}, 16'h0002);
			@(negedge clock) interrupt_acknowledge_n = 1'b1;
			repeat (2) @(negedge clock);
			$display("ack test done");
		end
	endtask
	task irq_seq;
		begin
			pulse(2'h1, 16'h0000);
			check({15'h0, host_interrupt_request}, {15'h0, ~address_strobe_mode});
			if (!address_strobe_mode)
				ack(1'b0);
			ack(1'b1);
			check({15'h0, host_interrupt_request}, {15'h0, ~address_strobe_mode});
			pulse(2'h2, 16'h0105);
			check({8'h00, adapter_int_bits}, 16'h0005);
			check({15'h0, host_interrupt_request}, {15'h0, ~address_strobe_mode});
			pulse(2'h2, 16'h0008);
			check({15'h0, host_interrupt_request}, {15'h0, address_strobe_mode});
			check({8'h00, adapter_int_bits}, 16'h0005);
			@(negedge clock) adapter_int_clear = 1'b1;
			@(negedge clock) adapter_int_clear = 1'b0;
			@(negedge clock);
			check({8'h00, adapter_int_bits}, 16'h0000);
			$display("irq test done");
		end
	endtask
	task dma(input w, input [1:0] b);
		begin
			r = {$random(seed), $random(seed)};
			@(negedge clock) dma_req = 1'b1;
			dma_write = w;
			dma_byte_en = b;
			{dma_addr, dma_addr_ext, dma_wdata, rd_word} = r[55:0];
			wait_cycles = {2'h0, r[57:56]};
			m = {{8{b[1]}}, {8{b[0]}}};
			k = 0;
			while (dma_done !== 1'b1 && k < 300) begin
				@(negedge clock);
				k = k + 1;
			end
			dma_req = 1'b0;
			check({15'h0, dma_done}, 16'h0001);
			check(acap[17:2], dma_addr);
			check({14'h0, acap[1:0]}, {14'h0, par(dma_addr[15:8]), par(dma_addr[7:0])});
			check({7'h0, xcap}, {7'h0, dma_addr_ext, par(dma_addr_ext)});
			if (w) begin
				check({14'h0, cap[17:16]}, {14'h0, b});
				check(cap[15:0] & m, dma_wdata & m);
			end else
				check(dma_rdata & m, rd_word & m);
			$display("dma test done");
		end
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		seed = 2412;
		{n_fail, check_count, cycles} = 96'h0;
		{nrst, address_strobe_mode, dma_req, dma_write, adapter_irq_set} = 5'h0;
		{host_int_write, adapter_int_clear, interrupt_acknowledge_n} = 3'h1;
		{dma_byte_en, dma_addr_ext, dma_addr, dma_wdata, host_int_wdata} = 58'h0;
		{int_vector, rd_word, wait_cycles} = 28'h0;
		do_reset(1'b0);
		ack(1'b0);
		ack(1'b1);
		irq_seq;
		do_reset(1'b1);
		irq_seq;
		dma(1'b1, 2'h1);
		dma(1'b1, 2'h2);
		dma(1'b0, 2'h3);
		for (j = 0; j < 12; j = j + 1) begin
			r = {$random(seed), $random(seed)};
			dma(r[0], (r[2:1] == 2'h0) ? 2'h3 : r[2:1]);
		end
		end_sim;
	end
endmodule

bind system_interface_unit host_port_properties chk (.*);

//--- include/host_port_defines.vh
// constants for the host dma and interrupt port
`ifndef HOST_PORT_DEFINES_VH
`define HOST_PORT_DEFINES_VH

// ****************************************
// interrupt register field positions
// ****************************************
`define INT_ADAPTER_BIT     0
`define INT_PURPOSE_MSB     7
`define INT_RST_SYS_BIT     8

// ****************************************
// widths
// ****************************************
`define AD_WIDTH            16
`define BYTE_WIDTH          8
`define VECTOR_WIDTH        8

// ****************************************
// reset values of pin registers
// ****************************************
`define RST_DBE_N           1'h1
`define RST_OWNED_N         1'h1
`define RST_DIR             1'h1
`define RST_ALE             1'h0
`define RST_STROBE_N        1'h1
`define RST_REQ             1'h0
`define RST_IRQ             1'h0
`define RST_BYTE            8'h00
`define RST_WORD            16'h0000

// ****************************************
// timing counts in clock cycles
// ****************************************
`define SYNC_STAGES         2
`define GRANT_TO_REQ_EDGES  2

`endif

//--- rtl/arb_sync.v
// two-stage synchroniser clocked on the falling edge
`timescale 1ns/100ps

module arb_sync (
	input  wire clock,
	input  wire nrst,
	input  wire din,
	output wire dout
);

	reg         stage1_r;
	reg         stage2_r;

	// pins are sampled on falling edges; idle level of these active-low pins is high
	always @(negedge clock) begin
		if (!nrst) begin
			stage1_r <= 1'h1;
			stage2_r <= 1'h1;
		end else begin
			stage1_r <= din;
			stage2_r <= stage1_r;
		end
	end

	assign dout = stage2_r;

endmodule

//--- rtl/system_interface_unit.v
// host facing dma, arbitration and interrupt port of the adapter
`timescale 1ns/100ps
`include "host_port_defines.vh"

module system_interface_unit (
	input  wire        clock,
	input  wire        nrst,
	input  wire        address_strobe_mode,
	input  wire        dma_req,
	input  wire        dma_write,
	input  wire [1:0]  dma_byte_en,
	input  wire [7:0]  dma_addr_ext,
	input  wire [15:0] dma_addr,
	input  wire [15:0] dma_wdata,
	output reg  [15:0] dma_rdata,
	output reg         dma_done,
	input  wire        adapter_irq_set,
	input  wire        host_int_write,
	input  wire [15:0] host_int_wdata,
	input  wire        adapter_int_clear,
	output reg  [7:0]  adapter_int_bits,
	input  wire [7:0]  int_vector,
	input  wire        bus_grant_in_n,
	input  wire        bus_busy_in_n,
	output wire        hold_or_bus_request_out,
	output reg         bus_owned_n,
	output reg         low_address_latch_pulse,
	output reg         extended_address_latch_pulse,
	output reg         data_buffer_enable_n,
	output reg         transceiver_direction,
	output wire        host_interrupt_request,
	input  wire        interrupt_acknowledge_n,
	output reg         address_strobe_n,
	output reg         upper_data_strobe_n,
	output reg         lower_data_strobe_n,
	output reg         strobe_oe,
	output reg         read_not_write,
	output reg         read_not_write_oe,
	input  wire        transfer_acknowledge_in,
	output reg         transfer_acknowledge_out,
	output reg         transfer_acknowledge_oe,
	input  wire [7:0]  addr_data_high_byte_in,
	output reg  [7:0]  addr_data_high_byte_out,
	output reg         addr_data_high_byte_oe,
	input  wire [7:0]  addr_data_low_byte_in,
	output reg  [7:0]  addr_data_low_byte_out,
	output reg         addr_data_low_byte_oe,
	output reg         parity_high,
	output reg         parity_high_oe,
	output reg         parity_low,
	output reg         parity_low_oe
);

	// ****************************************
	// states
	// ****************************************
	localparam [3:0] ST_IDLE = 4'h0;
	localparam [3:0] ST_WAIT = 4'h1;
	localparam [3:0] ST_REQ  = 4'h2;
	localparam [3:0] ST_XAL  = 4'h3;
	localparam [3:0] ST_ALE  = 4'h4;
	localparam [3:0] ST_ASTB = 4'h5;
	localparam [3:0] ST_DSTB = 4'h6;
	localparam [3:0] ST_XFER = 4'h7;
	localparam [3:0] ST_DONE = 4'h8;

	// odd parity over one byte
	function odd_par;
		input [7:0] b;
		begin
			odd_par = ~(^b);
		end
	endfunction

	reg  [3:0]  state_r;
	reg         req_r;
	reg         irq_r;
	reg         iack_d_r;
	reg         iack_first_r;
	reg         vec_drive_r;
	reg         tack_s_r;
	wire        grant_s;
	wire        busy_s;
	wire        iack_fall;
	wire        bus_free;

	// ****************************************
	// arbitration input sampling
	// ****************************************
	arb_sync u_grant_sync (
		.clock (clock),
		.nrst  (nrst),
		.din   (bus_grant_in_n),
		.dout  (grant_s)
	);
	arb_sync u_busy_sync (
		.clock (clock),
		.nrst  (nrst),
		.din   (bus_busy_in_n),
		.dout  (busy_s)
	);

	// acknowledge is sampled on the falling edge like grant and busy, but through a single stage
	always @(negedge clock) begin
		if (!nrst) begin
			tack_s_r <= 1'h1;
		end else begin
			tack_s_r <= transfer_acknowledge_in;
		end
	end

	assign bus_free = !grant_s && busy_s;

	// ****************************************
	// request polarity follows bus mode
	// ****************************************
	// both internal levels reset to zero, so reset shows low or high per mode
	assign hold_or_bus_request_out = address_strobe_mode ? ~req_r : req_r;
	assign host_interrupt_request  = address_strobe_mode ? ~irq_r : irq_r;

	// ****************************************
	// interrupt state
	// ****************************************
	always @(posedge clock) begin
		if (!nrst) begin
			irq_r <= `RST_IRQ;
			adapter_int_bits <= `RST_BYTE;
		end else begin
			// set wins over a clearing write in the same cycle
			if (adapter_irq_set) begin
				irq_r <= 1'h1;
			end else if (host_int_write && !host_int_wdata[`INT_RST_SYS_BIT]) begin
				irq_r <= 1'h0;
			end
			// purpose bits only count when the adapter bit is written as one
			if (host_int_write && host_int_wdata[`INT_ADAPTER_BIT]) begin
				adapter_int_bits <= adapter_int_bits
					| host_int_wdata[`INT_PURPOSE_MSB:0];
			end else if (adapter_int_clear) begin
				adapter_int_bits <= `RST_BYTE;
			end
		end
	end

	// ****************************************
	// interrupt acknowledge
	// ****************************************
	assign iack_fall = iack_d_r && !interrupt_acknowledge_n;

	always @(posedge clock) begin
		if (!nrst) begin
			iack_d_r <= 1'h1;
			iack_first_r <= 1'h0;
			vec_drive_r <= 1'h0;
		end else begin
			iack_d_r <= interrupt_acknowledge_n;
			// no check of the request level and no select decode here
			if (iack_fall && !address_strobe_mode) begin
				iack_first_r <= !iack_first_r;
			end
			if (interrupt_acknowledge_n) begin
				vec_drive_r <= 1'h0;
			end else if (iack_fall) begin
				vec_drive_r <= address_strobe_mode || iack_first_r;
			end
		end
	end

	// ****************************************
	// dma sequencer
	// ****************************************
	always @(posedge clock) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			req_r <= `RST_REQ;
			bus_owned_n <= `RST_OWNED_N;
			low_address_latch_pulse <= `RST_ALE;
			extended_address_latch_pulse <= `RST_ALE;
			data_buffer_enable_n <= `RST_DBE_N;
			transceiver_direction <= `RST_DIR;
			address_strobe_n <= `RST_STROBE_N;
			upper_data_strobe_n <= `RST_STROBE_N;
			lower_data_strobe_n <= `RST_STROBE_N;
			strobe_oe <= 1'h0;
			read_not_write <= 1'h1;
			read_not_write_oe <= 1'h0;
			transfer_acknowledge_out <= 1'h1;
			transfer_acknowledge_oe <= 1'h0;
			addr_data_high_byte_out <= `RST_BYTE;
			addr_data_low_byte_out <= `RST_BYTE;
			addr_data_high_byte_oe <= 1'h0;
			addr_data_low_byte_oe <= 1'h0;
			parity_high <= 1'h1;
			parity_low <= 1'h1;
			parity_high_oe <= 1'h0;
			parity_low_oe <= 1'h0;
			dma_rdata <= `RST_WORD;
			dma_done <= 1'h0;
		end else begin
			dma_done <= 1'h0;
			low_address_latch_pulse <= 1'h0;
			extended_address_latch_pulse <= 1'h0;
			case (state_r)
			ST_IDLE: begin
				// outside dma the pins serve the acknowledge read
				transceiver_direction <= vec_drive_r;
				data_buffer_enable_n <= !vec_drive_r;
				addr_data_low_byte_out <= int_vector;
				addr_data_low_byte_oe <= vec_drive_r;
				parity_low <= odd_par(int_vector);
				parity_low_oe <= vec_drive_r;
				transfer_acknowledge_out <= !(vec_drive_r && address_strobe_mode);
				transfer_acknowledge_oe <= vec_drive_r;
				if (dma_req && grant_s && !vec_drive_r) begin
					state_r <= ST_WAIT;
				end
			end
			ST_WAIT: begin
				// second rising edge since grant was seen high
				req_r <= 1'h1;
				state_r <= ST_REQ;
			end
			ST_REQ: begin
				if (bus_free) begin
					bus_owned_n <= 1'h0;
					req_r <= 1'h0;
					strobe_oe <= 1'h1;
					read_not_write_oe <= 1'h1;
					data_buffer_enable_n <= 1'h1;
					transceiver_direction <= 1'h0;
					addr_data_low_byte_out <= dma_addr_ext;
					addr_data_low_byte_oe <= 1'h1;
					parity_low <= odd_par(dma_addr_ext);
					parity_low_oe <= 1'h1;
					extended_address_latch_pulse <= 1'h1;
					state_r <= ST_XAL;
				end
			end
			ST_XAL: begin
				addr_data_high_byte_out <= dma_addr[15:8];
				addr_data_low_byte_out <= dma_addr[7:0];
				addr_data_high_byte_oe <= 1'h1;
				parity_high <= odd_par(dma_addr[15:8]);
				parity_low <= odd_par(dma_addr[7:0]);
				parity_high_oe <= 1'h1;
				low_address_latch_pulse <= 1'h1;
				state_r <= ST_ALE;
			end
			ST_ALE: begin
				// address already stands in the latch before the strobe falls
				address_strobe_n <= 1'h0;
				read_not_write <= !dma_write;
				if (dma_write) begin
					transceiver_direction <= 1'h1;
					data_buffer_enable_n <= 1'h0;
					addr_data_high_byte_out <= dma_wdata[15:8];
					addr_data_low_byte_out <= dma_wdata[7:0];
					parity_high <= odd_par(dma_wdata[15:8]);
					parity_low <= odd_par(dma_wdata[7:0]);
					addr_data_high_byte_oe <= dma_byte_en[1];
					addr_data_low_byte_oe <= dma_byte_en[0];
					parity_high_oe <= dma_byte_en[1];
					parity_low_oe <= dma_byte_en[0];
				end else begin
					upper_data_strobe_n <= !dma_byte_en[1];
					lower_data_strobe_n <= !dma_byte_en[0];
					addr_data_high_byte_oe <= 1'h0;
					addr_data_low_byte_oe <= 1'h0;
					parity_high_oe <= 1'h0;
					parity_low_oe <= 1'h0;
				end
				state_r <= ST_ASTB;
			end
			ST_ASTB: begin
				if (dma_write) begin
					upper_data_strobe_n <= !dma_byte_en[1];
					lower_data_strobe_n <= !dma_byte_en[0];
				end else begin
					data_buffer_enable_n <= 1'h0;
				end
				state_r <= ST_DSTB;
			end
			ST_DSTB: begin
				if (!tack_s_r) begin
					if (!dma_write) begin
						dma_rdata <= {addr_data_high_byte_in, addr_data_low_byte_in};
					end
					state_r <= ST_XFER;
				end
			end
			ST_XFER: begin
				address_strobe_n <= 1'h1;
				upper_data_strobe_n <= 1'h1;
				lower_data_strobe_n <= 1'h1;
				data_buffer_enable_n <= 1'h1;
				state_r <= ST_DONE;
			end
			ST_DONE: begin
				// give the bus back and return to idle pin levels
				bus_owned_n <= 1'h1;
				strobe_oe <= 1'h0;
				read_not_write <= 1'h1;
				read_not_write_oe <= 1'h0;
				transceiver_direction <= 1'h0;
				addr_data_high_byte_oe <= 1'h0;
				addr_data_low_byte_oe <= 1'h0;
				parity_high_oe <= 1'h0;
				parity_low_oe <= 1'h0;
				dma_done <= 1'h1;
				state_r <= ST_IDLE;
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end

endmodule
